// ### src/tws_pkg.sv
// package: register map, field positions, reset values and timing for the three-wire serial port
package tws_pkg;
    localparam int           TWS_AW          = 4;
    // register byte addresses on the avalon slave
    localparam logic [3:0]   OFF_CONTROL     = 4'h0;
    localparam logic [3:0]   OFF_STATUS      = 4'h4;
    localparam logic [3:0]   OFF_DATA        = 4'h8;
    localparam logic [3:0]   OFF_PORT        = 4'hc;
    // control register fields
    localparam int           CTL_RATE        = 0;
    localparam int           CTL_CTRL_SEL    = 4;
    localparam int           CTL_ORDER       = 5;
    localparam int           CTL_ENABLE      = 6;
    localparam int           CTL_IRQ_EN      = 7;
    localparam logic [7:0]   CTL_RESET       = 8'h00;
    localparam logic [7:0]   CTL_WMASK       = 8'hf1;
    // status register fields
    localparam int           STS_COLL        = 6;
    localparam int           STS_DONE        = 7;
    // port c bit positions taken over by the serial unit
    localparam int           PC_SCK          = 0;
    localparam int           PC_SDO          = 1;
    localparam int           PC_SDI          = 2;
    // last count of the half-period of the master clock, one less than its system clocks: divide by 2 or by 16
    localparam logic [2:0]   HALF_FAST       = 3'h0;
    localparam logic [2:0]   HALF_SLOW       = 3'h7;
    localparam logic [2:0]   BITS_LAST       = 3'h7;
    // master clock divisors, kept for reference by the bench
    localparam int           DIV_FAST        = 2;
    localparam int           DIV_SLOW        = 16;
    localparam logic [31:0]  UNMAPPED_READ   = 32'h0000_0000;
endpackage

// ### src/tws_cpu_if.sv
// interface: decoded cpu access strobes passed from the bus slave to the serial core
`timescale 1ns/1ps
`default_nettype none
interface tws_cpu_if;
    logic       status_rd;
    logic       data_rd;
    logic       data_wr;
    logic [7:0] wdata;
    modport bus  (output status_rd, output data_rd, output data_wr, output wdata);
    modport core (input status_rd, input data_rd, input data_wr, input wdata);
endinterface
`default_nettype wire

// ### src/tws_shift_core.sv
// serial shift engine: clock generator, bit counter, shift register and the two status flags
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module tws_shift_core
    import tws_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_b,
    input  wire logic  ce,
    tws_cpu_if.core    cpu,
    input  wire logic  enable,
    input  wire logic  ctrl_sel,
    input  wire logic  rate_select,
    input  wire logic  lsb_first,
    input  wire logic  sck_sync,
    input  wire logic  sdi_sync,
    output logic       sck_out,
    output logic       sdo_out,
    output logic [7:0] shift_data,
    output logic       busy,
    output logic       done_flag,
    output logic       coll_flag
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOW  = 3'b010,
        ST_HIGH = 3'b100
    } tws_mst_t;

    tws_mst_t   state;
    tws_mst_t   next_state;
    logic [2:0] bit_cnt;
    logic [2:0] div_cnt;
    logic       armed;
    logic       sck_prev;
    logic       slave_active;
    logic [1:0] samp_dly;
    logic [1:0] last_dly;
    logic [7:0] rx_bits;

    // one bit step of a shift register in the selected order
    function automatic logic [7:0] shift_in(input logic lsb, input logic [7:0] v, input logic b);
        return lsb ? {b, v[7:1]} : {v[6:0], b};
    endfunction

    // one place for the edge of the serial clock that shifts
    wire [2:0] half_len  = rate_select ? HALF_SLOW : HALF_FAST;
    wire       div_done  = (div_cnt == half_len);
    wire       s_rise    = !ctrl_sel && sck_sync && !sck_prev && !done_flag;
    wire       s_fall    = !ctrl_sel && !sck_sync && sck_prev && !done_flag;
    wire       m_rise    = (state == ST_LOW) && div_done;
    wire       m_fall    = (state == ST_HIGH) && div_done && (bit_cnt != 3'h0);
    wire       rise      = enable && (ctrl_sel ? m_rise : s_rise);
    wire       fall      = enable && (ctrl_sel ? m_fall : s_fall);
    wire       last_bit  = rise && (bit_cnt == BITS_LAST);
    wire       data_acc  = cpu.data_rd || cpu.data_wr;
    wire       clear_seq = armed && data_acc;
    wire       collide   = data_acc && busy && !armed;
    wire       wr_ok     = cpu.data_wr && !busy && !done_flag;
    wire       start     = enable && ctrl_sel && wr_ok && state == ST_IDLE;
    wire       in_bit    = sdi_sync;
    // controller input lags by the synchroniser depth, so it is taken two clocks after the rising edge
    wire       sample    = samp_dly[1] || (rise && !ctrl_sel);
    wire       rx_last   = last_dly[1] || (last_bit && !ctrl_sel);
    wire       shift_out = fall && (bit_cnt != 3'h0);
    wire [7:0] rx_next   = shift_in(lsb_first, rx_bits, in_bit);
    wire [7:0] tx_next   = shift_in(lsb_first, shift_data, 1'b0);

    assign busy    = (state != ST_IDLE) || slave_active || (samp_dly != 2'h0);
    assign sck_out = (state != ST_LOW);
    assign sdo_out = lsb_first ? shift_data[0] : shift_data[7];

    // master clock state machine; first low phase begins on the start write
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: if (start) next_state = ST_LOW;
            ST_LOW:  if (div_done) next_state = ST_HIGH;
            ST_HIGH: if (div_done || bit_cnt == 3'h0) next_state = (bit_cnt == 3'h0) ? ST_IDLE : ST_LOW;
            default: next_state = ST_IDLE;
        endcase
        if (!enable || !ctrl_sel)
            next_state = ST_IDLE;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state    <= ST_IDLE;
            div_cnt  <= 3'h0;
            sck_prev <= 1'b1;
        end else if (ce) begin
            state    <= next_state;
            div_cnt  <= (div_done || next_state != state) ? 3'h0 : div_cnt + 3'h1;
            sck_prev <= sck_sync;
        end
    end

    // bit counter wraps after the eighth clock, halting the transfer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt      <= 3'h0;
            slave_active <= 1'b0;
        end else if (ce) begin
            if (!enable) begin
                bit_cnt      <= 3'h0;
                slave_active <= 1'b0;
            end else if (rise) begin
                bit_cnt      <= bit_cnt + 3'h1;
                slave_active <= !ctrl_sel && !last_bit;
            end else if (s_fall) begin
                slave_active <= 1'b1;
            end
        end
    end

    // delayed sampling strobes for controller mode; cleared when the unit is disabled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            samp_dly <= 2'h0;
            last_dly <= 2'h0;
        end else if (ce) begin
            samp_dly <= enable ? {samp_dly[0], rise && ctrl_sel} : 2'h0;
            last_dly <= enable ? {last_dly[0], last_bit && ctrl_sel} : 2'h0;
        end
    end

    // data register: shifted out on falling edges, replaced by the received byte at the end; not reset
    always_ff @(posedge clk) begin
        if (ce) begin
            if (sample)
                rx_bits <= rx_next;
            if (rx_last)
                shift_data <= rx_next;
            else if (shift_out)
                shift_data <= tx_next;
            else if (wr_ok || (cpu.data_wr && clear_seq && !busy))
                shift_data <= cpu.wdata;
        end
    end

    // flags: a new event wins over the clearing sequence
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_flag <= 1'b0;
            coll_flag <= 1'b0;
            armed     <= 1'b0;
        end else if (ce) begin
            if (last_bit)
                done_flag <= 1'b1;
            else if (clear_seq)
                done_flag <= 1'b0;
            if (collide)
                coll_flag <= 1'b1;
            else if (clear_seq)
                coll_flag <= 1'b0;
            if (cpu.status_rd)
                armed <= done_flag;
            else if (data_acc)
                armed <= 1'b0;
        end
    end

    a_done_on_eighth: assert property (@(posedge clk) disable iff (!rst_b)
        ce && last_bit |=> done_flag) else $error("done flag not set after eighth clock");
    a_idle_clock_high: assert property (@(posedge clk) disable iff (!rst_b)
        state == ST_IDLE |-> sck_out) else $error("master clock not high at idle");
    a_halt_on_done: assert property (@(posedge clk) disable iff (!rst_b)
        done_flag && !ctrl_sel |-> !rise) else $error("slave shifted while done set");
    a_collide_sets: assert property (@(posedge clk) disable iff (!rst_b)
        ce && collide |=> coll_flag) else $error("collision not flagged");
    a_clear_needs_seq: assert property (@(posedge clk) disable iff (!rst_b)
        ce && done_flag && !clear_seq |=> done_flag) else $error("done flag cleared without sequence");
    a_coll_clear_seq: assert property (@(posedge clk) disable iff (!rst_b)
        ce && coll_flag && !clear_seq |=> coll_flag) else $error("collision cleared without sequence");
    a_start_low: assert property (@(posedge clk) disable iff (!rst_b)
        ce && start |=> !sck_out) else $error("start write did not begin clocking");
    a_fast_half: assert property (@(posedge clk) disable iff (!rst_b)
        ce && state == ST_LOW && !rate_select |=> state != ST_LOW)
        else $error("fast clock low phase longer than one cycle");
    a_collide_keeps: assert property (@(posedge clk) disable iff (!rst_b)
        ce && busy && cpu.data_wr && !shift_out && !rx_last |=> $stable(shift_data))
        else $error("collision disturbed shift data");
    a_disable_stops: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !enable |=> state == ST_IDLE) else $error("clock ran while disabled");

    c_master_byte: cover property (@(posedge clk) disable iff (!rst_b) last_bit && ctrl_sel);
    c_slave_byte:  cover property (@(posedge clk) disable iff (!rst_b) last_bit && !ctrl_sel);
    c_collision:   cover property (@(posedge clk) disable iff (!rst_b) collide);
    c_clear:       cover property (@(posedge clk) disable iff (!rst_b) clear_seq);
endmodule
`default_nettype wire

// ### src/tws_top.sv
// top: avalon-mm register slave, port c pin sharing and the serial core
`timescale 1ns/1ps
`default_nettype none
// How it works
// - enable claims port c bits 0,1,2 as clock, data out, data in
// - controller mode: data write starts clock at system clock over 2 or 16
// - three-bit counter runs from first clock, sets done and halts after eight
// - controller serial clock idles high, also after the eighth pulse
// - serial output changes on the falling serial clock edge
// - follower mode clocks from the pin; rate select ignored
// - follower ignores further clocks while done flag is set
// - input bits sampled into the shift register, also the data register
// - done sets flag; interrupt request when done interrupt enable is set
// - done clears only by status read with flag set, then data access
// - data access during shifting without clearing sequence sets collision
// - collision clears by status read with done flag set, then data access
// - port reads return pin levels; port data register unused
// - data out pin drives while enabled, input when disabled
// - data in pin is purely an input while enabled
// - clock pin is output as controller, input as follower
// - bit order select: set means least significant bit first
// - rate select: set divides by 16, clear by 2
// - done flag set on the rising edge of the eighth clock
// - colliding access leaves the running transfer untouched
module tws_top
    import tws_pkg::*;
(
    input  wire logic                  CLOCK,
    input  wire logic                  RST_B,
    input  wire logic                  CE,
    input  wire logic [tws_pkg::TWS_AW-1:0] AVS_ADDRESS,
    input  wire logic                  AVS_READ,
    input  wire logic                  AVS_WRITE,
    input  wire logic [31:0]           AVS_WRITEDATA,
    input  wire logic [3:0]            AVS_BYTEENABLE,
    output logic [31:0]                AVS_READDATA,
    output logic                       AVS_WAITREQUEST,
    input  wire logic [2:0]            PORT_C_IN,
    output logic [2:0]                 PORT_C_OUT,
    output logic [2:0]                 PORT_C_OE,
    output logic                       IRQ
);
    import tws_pkg::*;

    tws_cpu_if cpu ();

    logic [7:0] control;
    logic [1:0] sck_meta;
    logic [1:0] sdi_meta;
    logic [2:0] pin_meta0;
    logic [2:0] pin_meta1;
    logic       answered;
    logic       sck_out;
    logic       sdo_out;
    logic [7:0] shift_data;
    logic       busy;
    logic       done_flag;
    logic       coll_flag;

    wire enable      = control[CTL_ENABLE];
    wire ctrl_sel    = control[CTL_CTRL_SEL];
    // one access per request: answered on the cycle after it is seen
    wire req         = (AVS_READ || AVS_WRITE) && !answered && CE;
    wire hit_ctl     = AVS_ADDRESS == OFF_CONTROL;
    wire hit_sts     = AVS_ADDRESS == OFF_STATUS;
    wire hit_dat     = AVS_ADDRESS == OFF_DATA;
    wire hit_port    = AVS_ADDRESS == OFF_PORT;
    wire [7:0] status = {done_flag, coll_flag, 6'h00};

    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !answered;
    assign cpu.status_rd   = req && AVS_READ && hit_sts;
    assign cpu.data_rd     = req && AVS_READ && hit_dat;
    assign cpu.data_wr     = req && AVS_WRITE && hit_dat && AVS_BYTEENABLE[0];
    assign cpu.wdata       = AVS_WRITEDATA[7:0];
    assign IRQ             = done_flag && control[CTL_IRQ_EN];

    // pins: clock out only as controller, data out while enabled, data in never driven
    assign PORT_C_OUT = {1'b0, sdo_out, sck_out};
    assign PORT_C_OE  = {1'b0, enable, enable && ctrl_sel};

    // two-flop synchronisers for pins; the first stage feeds only the second
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            sck_meta  <= 2'h3;
            sdi_meta  <= 2'h0;
            pin_meta0 <= 3'h0;
            pin_meta1 <= 3'h0;
        end else if (CE) begin
            sck_meta  <= {sck_meta[0], PORT_C_IN[PC_SCK]};
            sdi_meta  <= {sdi_meta[0], PORT_C_IN[PC_SDI]};
            pin_meta0 <= PORT_C_IN;
            pin_meta1 <= pin_meta0;
        end
    end

    // control register and bus answer; reserved bits stay zero
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            control      <= CTL_RESET;
            answered     <= 1'b0;
            AVS_READDATA <= UNMAPPED_READ;
        end else if (CE) begin
            answered <= req;
            if (req && AVS_WRITE && hit_ctl && AVS_BYTEENABLE[0])
                control <= AVS_WRITEDATA[7:0] & CTL_WMASK;
            if (req && AVS_READ) begin
                if (hit_ctl)
                    AVS_READDATA <= {24'h0, control};
                else if (hit_sts)
                    AVS_READDATA <= {24'h0, status};
                else if (hit_dat)
                    AVS_READDATA <= {24'h0, shift_data};
                else if (hit_port)
                    AVS_READDATA <= {29'h0, pin_meta1};
                else
                    AVS_READDATA <= UNMAPPED_READ;
            end
        end
    end

    tws_shift_core u_core (
        .clk         (CLOCK),
        .rst_b       (RST_B),
        .ce          (CE),
        .cpu         (cpu.core),
        .enable      (enable),
        .ctrl_sel    (ctrl_sel),
        .rate_select (control[CTL_RATE]),
        .lsb_first   (control[CTL_ORDER]),
        .sck_sync    (sck_meta[1]),
        .sdi_sync    (sdi_meta[1]),
        .sck_out     (sck_out),
        .sdo_out     (sdo_out),
        .shift_data  (shift_data),
        .busy        (busy),
        .done_flag   (done_flag),
        .coll_flag   (coll_flag)
    );

    a_bus_answer: assert property (@(posedge CLOCK) disable iff (!RST_B)
        CE && req |=> !AVS_WAITREQUEST) else $error("bus request not answered in one cycle");
    a_irq_gate: assert property (@(posedge CLOCK) disable iff (!RST_B)
        IRQ |-> done_flag && control[CTL_IRQ_EN]) else $error("irq without done flag");
    a_pins_off: assert property (@(posedge CLOCK) disable iff (!RST_B)
        !enable |-> PORT_C_OE == 3'h0) else $error("pin driven while disabled");
    c_irq: cover property (@(posedge CLOCK) disable iff (!RST_B) $rose(IRQ));
endmodule
`default_nettype wire

// ### sim/tws_far_model.sv
// far-side serial device: follower answering a controller, or controller driving the clock
`timescale 1ns/1ps
`default_nettype none
module tws_far_model (
    input  wire logic clk,
    input  wire logic sck_pin,
    input  wire logic sdo_pin,
    input  wire logic lsb_first,
    output logic      sck_drv,
    output logic      sdi_drv
);
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    int         nbit = 0;
    // clock line rests high before enable and between frames
    initial begin
        sck_drv = 1'b1;
        sdi_drv = 1'b1;
    end
    // own data changes on the falling edge, in the selected order
    always @(negedge sck_pin) sdi_drv <= lsb_first ? tx[nbit[2:0]] : tx[3'h7 - nbit[2:0]];
    // sample on the rising edge; once the hold time is over the line shows garbage
    always @(posedge sck_pin) begin
        rx   <= lsb_first ? {sdo_pin, rx[7:1]} : {rx[6:0], sdo_pin};
        nbit <= nbit + 1;
        if (nbit == 7) begin
            repeat (4) @(posedge clk);
            sdi_drv <= ~sdi_drv;
        end
    end
    task automatic load(input logic [7:0] b);
        tx   = b;
        nbit = 0;
    endtask
    // n pulses of half system clocks per phase; half >= 1 never beats the system clock
    task automatic run(input int half, input int n);
        repeat (n) begin
            @(posedge clk) sck_drv <= 1'b0;
            repeat (half - 1) @(posedge clk);
            @(posedge clk) sck_drv <= 1'b1;
            repeat (half - 1) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ### sim/three_wire_serial_port_tb.sv
// self-checking bench: register traffic and serial frames in both directions of control
`timescale 1ns/1ps
`default_nettype none
module three_wire_serial_port_tb;
    import tws_pkg::*;
    logic        CLOCK, RST_B, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ;
    logic [3:0]  AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA;
    logic [2:0]  PORT_C_OUT, PORT_C_OE;
    wire  [2:0]  PORT_C_IN;
    logic        sck_drv, sdi_drv, lsb;
    int          failures = 0;
    int          n_checks = 0;
    int          low_run = 0;
    int          last_low = 0;
    logic [31:0] exp_q[$];
    string       what_q[$];
    logic [7:0]  tx_b, rx_b, ctl;

    // pin levels: a driving side wins, pull-ups hold undriven lines high
    assign PORT_C_IN = {sdi_drv, PORT_C_OE[1] ? PORT_C_OUT[1] : 1'b1, PORT_C_OE[0] ? PORT_C_OUT[0] : sck_drv};

    tws_top tws_top_i (.CLOCK(CLOCK), .RST_B(RST_B), .CE(1'b1), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .PORT_C_IN(PORT_C_IN), .PORT_C_OUT(PORT_C_OUT), .PORT_C_OE(PORT_C_OE), .IRQ(IRQ));
    tws_far_model tws_far_model_i (.clk(CLOCK), .sck_pin(PORT_C_IN[0]), .sdo_pin(PORT_C_IN[1]),
        .lsb_first(lsb), .sck_drv(sck_drv), .sdi_drv(sdi_drv));

    always #4 CLOCK = ~CLOCK;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // hold the request until waitrequest is seen low at a rising edge, then release
    task automatic bus_req(input logic [3:0] addr, input logic rd, input logic [7:0] wd);
        int   n;
        logic ack;
        n   = 0;
        ack = 1'b0;
        @(posedge CLOCK);
        AVS_ADDRESS   <= addr;
        AVS_READ      <= rd;
        AVS_WRITE     <= ~rd;
        AVS_WRITEDATA <= {24'h0, wd};
        while (!ack) begin
            @(posedge CLOCK);
            ack = (AVS_WAITREQUEST === 1'b0);
            n++;
            if (n > 50) begin
                failures++;
                print_verdict();
            end
        end
        AVS_READ  <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    // the expected read value is noted first, the watcher below compares it
    task automatic bus_read(input logic [3:0] addr, input logic [7:0] exp, input string what);
        exp_q.push_back({24'h0, exp});
        what_q.push_back(what);
        bus_req(addr, 1'b1, 8'h00);
    endtask
    task automatic wait_irq(input int limit);
        int n;
        n = 0;
        while (IRQ !== 1'b1) begin
            @(negedge CLOCK);
            n++;
            if (n > limit) begin
                failures++;
                print_verdict();
            end
        end
    endtask

    // read answers are taken at the edge that ends the request
    always @(posedge CLOCK) begin
        if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && exp_q.size() > 0) begin
            check(what_q.pop_front(), exp_q.pop_front(), AVS_READDATA);
        end
    end
    // length of the last low phase of the generated clock, in system clocks
    always @(negedge CLOCK) begin
        if (PORT_C_OE[0] && PORT_C_OUT[0] === 1'b0) low_run++;
        else if (low_run != 0) begin
            last_low = low_run;
            low_run  = 0;
        end
    end

    initial begin
        CLOCK         = 1'b0;
        RST_B         = 1'b0;
        AVS_ADDRESS   = 4'h0;
        AVS_READ      = 1'b0;
        AVS_WRITE     = 1'b0;
        AVS_WRITEDATA = 32'h0;
        lsb           = 1'b0;
        void'($urandom(19437));
        repeat (5) @(posedge CLOCK);
        RST_B <= 1'b1;
        // reset values, reserved bits and an unmapped place
        bus_read(OFF_CONTROL, CTL_RESET, "control");
        bus_read(OFF_STATUS, 8'h00, "status");
        bus_read(4'h2, 8'h00, "unmapped");
        bus_req(OFF_CONTROL, 1'b0, 8'hff);
        bus_read(OFF_CONTROL, CTL_WMASK, "control");
        @(negedge CLOCK);
        check("port oe", 3'b011, PORT_C_OE);
        // controller transfers at both rates and both orders; one collides mid-byte
        for (int c = 0; c < 4; c++) begin
            lsb  = c[1];
            ctl  = {2'b11, c[1], 1'b1, 3'b000, c[0]};
            tx_b = 8'($urandom);
            rx_b = 8'($urandom);
            bus_req(OFF_CONTROL, 1'b0, ctl);
            tws_far_model_i.load(rx_b);
            bus_req(OFF_DATA, 1'b0, tx_b);
            if (c == 1) bus_req(OFF_DATA, 1'b0, ~tx_b);
            wait_irq(400);
            @(negedge CLOCK);
            check("low phase", c[0] ? DIV_SLOW / 2 : DIV_FAST / 2, last_low);
            check("clock idle", 1'b1, PORT_C_OUT[0]);
            check("far rx", tx_b, tws_far_model_i.rx);
            bus_read(OFF_STATUS, c == 1 ? 8'hc0 : 8'h80, "status");
            bus_read(OFF_DATA, rx_b, "data");
            bus_read(OFF_STATUS, 8'h00, "status");
            check("irq", 1'b0, IRQ);
        end
        // follower with rate select set; extra clocks and a write while done are ignored
        lsb  = 1'b0;
        tx_b = 8'($urandom);
        rx_b = 8'($urandom);
        bus_req(OFF_CONTROL, 1'b0, 8'hc1);
        @(negedge CLOCK);
        check("port oe", 3'b010, PORT_C_OE);
        tws_far_model_i.load(rx_b);
        bus_req(OFF_DATA, 1'b0, tx_b);
        tws_far_model_i.run(4, 8);
        wait_irq(50);
        check("far rx", tx_b, tws_far_model_i.rx);
        tws_far_model_i.run(4, 2);
        bus_req(OFF_DATA, 1'b0, ~rx_b);
        bus_read(OFF_STATUS, 8'h80, "status");
        bus_read(OFF_DATA, rx_b, "data");
        bus_read(OFF_STATUS, 8'h00, "status");
        // disabled: pins fall back to inputs and port reads follow the pins
        bus_req(OFF_CONTROL, 1'b0, 8'h00);
        @(negedge CLOCK);
        check("port oe", 3'b000, PORT_C_OE);
        repeat (3) @(posedge CLOCK);
        bus_read(OFF_PORT, {5'h00, PORT_C_IN}, "port pins");
        // reset in mid-run clears the controls again
        bus_req(OFF_CONTROL, 1'b0, 8'hf1);
        @(posedge CLOCK);
        RST_B <= 1'b0;
        repeat (2) @(posedge CLOCK);
        RST_B <= 1'b1;
        bus_read(OFF_CONTROL, 8'h00, "control");
        print_verdict();
    end
endmodule
`default_nettype wire
